//--- hdl/ofd_cfg.svh
`ifndef OFD_CFG_SVH
`define OFD_CFG_SVH
// apb byte addresses
`define OFD_A_CTRL 8'h00
`define OFD_A_STAT 8'h04
`define OFD_A_BASE 8'h08
`define OFD_A_FRAME 8'h0c
`define OFD_A_SRC 8'h10
`define OFD_A_DST 8'h14
`define OFD_A_PSW 8'h18
`define OFD_A_EA 8'h1c
`define OFD_A_OFS 8'h20
`define OFD_A_INFO 8'h24
// operand byte fields
`define OFD_W_BIT 0
`define OFD_MOD_F 7:6
`define OFD_REG_F 5:3
`define OFD_RM_F 2:0
`define OFD_MOD_NONE 2'h0
`define OFD_MOD_S8 2'h1
`define OFD_MOD_W16 2'h2
`define OFD_MOD_REG 2'h3
`define OFD_RM_DIRECT 3'h6
// status word flag positions and writable mask
`define OFD_PSW_CF 0
`define OFD_PSW_PF 2
`define OFD_PSW_AF 4
`define OFD_PSW_ZF 6
`define OFD_PSW_SF 7
`define OFD_PSW_TF 8
`define OFD_PSW_IF 9
`define OFD_PSW_DF 10
`define OFD_PSW_OF 11
`define OFD_PSW_MASK 16'h0fd5
`define OFD_RST16 16'h0000
`endif

//--- hdl/ofd_pkg.sv
package ofd_pkg;
	typedef enum logic [4:0] {
		ST_OPC = 5'h01,
		ST_MODRM = 5'h02,
		ST_OFLO = 5'h04,
		ST_OFHI = 5'h08,
		ST_DONE = 5'h10
	} ofd_state_t;
	// {byte, code}: word registers 0..7, byte registers 8..15
	typedef enum logic [3:0] {
		accumulator_word = 4'h0, count_word = 4'h1, data_word_reg = 4'h2, base_word = 4'h3,
		stack_pointer = 4'h4, frame_base_pointer = 4'h5, source_index = 4'h6, destination_index = 4'h7,
		accumulator_low = 4'h8, count_low = 4'h9, data_low = 4'ha, base_low = 4'hb,
		accumulator_high = 4'hc, count_high = 4'hd, data_high = 4'he, base_high = 4'hf
	} ofd_reg_t;
	typedef enum logic [1:0] {
		extra_segment = 2'h0, code_segment = 2'h1, stack_segment = 2'h2, data_segment = 2'h3
	} ofd_seg_t;
	function automatic ofd_reg_t ofd_reg_map(input logic word, input logic [2:0] code);
		return ofd_reg_t'({~word, code});
	endfunction
	function automatic ofd_seg_t ofd_seg_map(input logic [1:0] code);
		return ofd_seg_t'(code);
	endfunction
endpackage

//--- hdl/ofd_ea_if.sv
`timescale 1ns/1ps
interface ofd_ea_if;
	logic [1:0] mode;
	logic [2:0] rm;
	logic [7:0] ofs_lo, ofs_hi;
	logic [15:0] base, frame, src, dst;
	logic [15:0] ofs_val, ea;
	logic direct, mem_access;
	modport calc (input mode, rm, ofs_lo, ofs_hi, base, frame, src, dst,
		output ofs_val, ea, direct, mem_access);
	modport ctl (output mode, rm, ofs_lo, ofs_hi, base, frame, src, dst,
		input ofs_val, ea, direct, mem_access);
endinterface

//--- hdl/ofd_ea_calc.sv
`timescale 1ns/1ps
`include "ofd_cfg.svh"
module ofd_ea_calc (
	ofd_ea_if.calc bus
);
	import ofd_pkg::*;
	logic [15:0] pair, ofs, sum;
	always_comb begin
		pair = {bus.ofs_hi, bus.ofs_lo};
		case (bus.mode)
		`OFD_MOD_S8: ofs = {{8{bus.ofs_lo[7]}}, bus.ofs_lo};
		`OFD_MOD_W16: ofs = pair;
		default: ofs = `OFD_RST16;
		endcase
		// 16-bit adders wrap on purpose
		case (bus.rm)
		3'h0: sum = bus.base + bus.src + ofs;
		3'h1: sum = bus.base + bus.dst + ofs;
		3'h2: sum = bus.frame + bus.src + ofs;
		3'h3: sum = bus.frame + bus.dst + ofs;
		3'h4: sum = bus.src + ofs;
		3'h5: sum = bus.dst + ofs;
		3'h6: sum = bus.frame + ofs;
		default: sum = bus.base + ofs;
		endcase
	end
	assign bus.direct = (bus.mode == `OFD_MOD_NONE) && (bus.rm == `OFD_RM_DIRECT);
	assign bus.ea = bus.direct ? pair : sum;
	assign bus.ofs_val = ofs;
	assign bus.mem_access = (bus.mode != `OFD_MOD_REG);
endmodule // ofd_ea_calc

//--- hdl/ofd_decoder.sv
`timescale 1ns/1ps
`include "ofd_cfg.svh"
// Function
// - size bit 1 means word operands, 0 means byte operands.
// - kind 11 makes the rm field a register selector with no memory access.
// - kind 00 uses a zero offset and fetches no offset bytes, except direct addressing.
// - kind 01 fetches only the low offset byte and sign-extends it to 16 bits.
// - kind 10 fetches both offset bytes, high above low.
// - kind 00 with rm 110 uses the two offset bytes directly as the address.
// - rm 000 and 001 add base_word plus source or destination index plus offset.
// - rm 010 and 011 add frame_base_pointer plus source or destination index plus offset.
// - rm 100 adds source_index and rm 101 adds destination_index to the offset.
// - rm 110 adds frame_base_pointer and rm 111 adds base_word to the offset.
// - offset bytes follow the operand byte and come before any immediate data.
// - the status word holds its nine flags at bits 0,2,4,6,7,8,9,10,11.
// - register codes map to word or byte registers depending on the size bit.
// - segment codes 00..11 select extra, code, stack and data segments.
module ofd_decoder (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic fetch_valid,
	input wire logic [7:0] fetch_byte,
	output logic fetch_ready,
	output logic result_valid,
	output logic [15:0] effective_address,
	output logic [15:0] offset_value,
	output logic operand_is_word,
	output logic memory_access,
	output ofd_pkg::ofd_reg_t operand_reg,
	output ofd_pkg::ofd_reg_t rm_reg,
	output ofd_pkg::ofd_seg_t segment_sel
);
	import ofd_pkg::*;

	ofd_ea_if ea_bus ();

	ofd_ea_calc u_calc (
		.bus(ea_bus.calc)
	);

	// software-visible register group
	logic en_q, en_d;
	logic [15:0] base_q, base_d, frame_q, frame_d;
	logic [15:0] src_q, src_d, dst_q, dst_d;
	logic [15:0] psw_q, psw_d;
	logic [31:0] prdata_q, prdata_d;
	logic [31:0] rd;
	logic hit;

	// decode group
	ofd_state_t st_q, st_d;
	logic word_q, word_d;
	logic [1:0] mode_q, mode_d;
	logic [2:0] regf_q, regf_d, rm_q, rm_d;
	logic [7:0] lo_q, lo_d, hi_q, hi_d;
	logic done_q, done_d, pulse_q, pulse_d;
	logic [15:0] ea_q, ea_d, ofs_q, ofs_d;
	logic mem_q, mem_d;
	ofd_reg_t opr_q, opr_d, rmr_q, rmr_d;
	ofd_seg_t seg_q, seg_d;
	logic take;

	assign ea_bus.mode = mode_q;
	assign ea_bus.rm = rm_q;
	assign ea_bus.ofs_lo = lo_q;
	assign ea_bus.ofs_hi = hi_q;
	assign ea_bus.base = base_q;
	assign ea_bus.frame = frame_q;
	assign ea_bus.src = src_q;
	assign ea_bus.dst = dst_q;

	// one wait-free access phase; prdata is sampled at setup so it can come from a flop
	assign pready = 1'b1;
	assign pslverr = psel && penable && !hit;
	assign prdata = prdata_q;

	always_comb begin
		en_d = en_q;
		base_d = base_q;
		frame_d = frame_q;
		src_d = src_q;
		dst_d = dst_q;
		psw_d = psw_q;
		prdata_d = prdata_q;
		hit = 1'b1;
		rd = 32'h0000_0000;
		case (paddr)
		`OFD_A_CTRL: rd = 32'(en_q);
		`OFD_A_STAT: rd = 32'({st_q != ST_OPC, done_q});
		`OFD_A_BASE: rd = 32'(base_q);
		`OFD_A_FRAME: rd = 32'(frame_q);
		`OFD_A_SRC: rd = 32'(src_q);
		`OFD_A_DST: rd = 32'(dst_q);
		`OFD_A_PSW: rd = 32'(psw_q);
		`OFD_A_EA: rd = 32'(ea_q);
		`OFD_A_OFS: rd = 32'(ofs_q);
		`OFD_A_INFO: rd = 32'({seg_q, rmr_q, opr_q, mem_q, word_q});
		default: hit = 1'b0;
		endcase
		if (psel && !penable) begin
			prdata_d = hit ? rd : 32'h0000_0000;
		end
		if (psel && penable && pwrite) begin
			case (paddr)
			`OFD_A_CTRL: en_d = pwdata[0];
			`OFD_A_BASE: base_d = pwdata[15:0];
			`OFD_A_FRAME: frame_d = pwdata[15:0];
			`OFD_A_SRC: src_d = pwdata[15:0];
			`OFD_A_DST: dst_d = pwdata[15:0];
			`OFD_A_PSW: psw_d = pwdata[15:0] & `OFD_PSW_MASK;
			default: en_d = en_q;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			en_q <= 1'b0;
			base_q <= `OFD_RST16;
			frame_q <= `OFD_RST16;
			src_q <= `OFD_RST16;
			dst_q <= `OFD_RST16;
			psw_q <= `OFD_RST16;
			prdata_q <= 32'h0000_0000;
		end else begin
			en_q <= en_d;
			base_q <= base_d;
			frame_q <= frame_d;
			src_q <= src_d;
			dst_q <= dst_d;
			psw_q <= psw_d;
			prdata_q <= prdata_d;
		end
	end

	// byte stream: opcode, operand byte, offset bytes; immediate data is left to the datapath
	assign fetch_ready = en_q && (st_q != ST_DONE);
	assign take = fetch_valid && fetch_ready;

	always_comb begin
		st_d = st_q;
		word_d = word_q;
		mode_d = mode_q;
		regf_d = regf_q;
		rm_d = rm_q;
		lo_d = lo_q;
		hi_d = hi_q;
		done_d = done_q;
		pulse_d = 1'b0;
		ea_d = ea_q;
		ofs_d = ofs_q;
		mem_d = mem_q;
		opr_d = opr_q;
		rmr_d = rmr_q;
		seg_d = seg_q;
		case (st_q)
		ST_OPC: begin
			if (take) begin
				word_d = fetch_byte[`OFD_W_BIT];
				done_d = 1'b0;
				st_d = ST_MODRM;
			end
		end
		ST_MODRM: begin
			if (take) begin
				mode_d = fetch_byte[`OFD_MOD_F];
				regf_d = fetch_byte[`OFD_REG_F];
				rm_d = fetch_byte[`OFD_RM_F];
				lo_d = 8'h00;
				hi_d = 8'h00;
				if (fetch_byte[`OFD_MOD_F] == `OFD_MOD_REG) begin
					st_d = ST_DONE;
				end else if (fetch_byte[`OFD_MOD_F] != `OFD_MOD_NONE) begin
					st_d = ST_OFLO;
				end else if (fetch_byte[`OFD_RM_F] == `OFD_RM_DIRECT) begin
					st_d = ST_OFLO;
				end else begin
					st_d = ST_DONE;
				end
			end
		end
		ST_OFLO: begin
			if (take) begin
				lo_d = fetch_byte;
				if (mode_q == `OFD_MOD_W16 || ea_bus.direct) begin
					st_d = ST_OFHI;
				end else begin
					st_d = ST_DONE;
				end
			end
		end
		ST_OFHI: begin
			if (take) begin
				hi_d = fetch_byte;
				st_d = ST_DONE;
			end
		end
		ST_DONE: begin
			ea_d = ea_bus.mem_access ? ea_bus.ea : `OFD_RST16;
			ofs_d = ea_bus.ofs_val;
			mem_d = ea_bus.mem_access;
			opr_d = ofd_reg_map(word_q, regf_q);
			rmr_d = ofd_reg_map(word_q, rm_q);
			seg_d = ofd_seg_map(regf_q[1:0]);
			done_d = 1'b1;
			pulse_d = 1'b1;
			st_d = ST_OPC;
		end
		default: st_d = ST_OPC;
		endcase
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			st_q <= ST_OPC;
			word_q <= 1'b0;
			mode_q <= `OFD_MOD_NONE;
			regf_q <= 3'h0;
			rm_q <= 3'h0;
			lo_q <= 8'h00;
			hi_q <= 8'h00;
			done_q <= 1'b0;
			pulse_q <= 1'b0;
			ea_q <= `OFD_RST16;
			ofs_q <= `OFD_RST16;
			mem_q <= 1'b0;
			opr_q <= accumulator_word;
			rmr_q <= accumulator_word;
			seg_q <= extra_segment;
		end else begin
			st_q <= st_d;
			word_q <= word_d;
			mode_q <= mode_d;
			regf_q <= regf_d;
			rm_q <= rm_d;
			lo_q <= lo_d;
			hi_q <= hi_d;
			done_q <= done_d;
			pulse_q <= pulse_d;
			ea_q <= ea_d;
			ofs_q <= ofs_d;
			mem_q <= mem_d;
			opr_q <= opr_d;
			rmr_q <= rmr_d;
			seg_q <= seg_d;
		end
	end

	assign result_valid = pulse_q;
	assign effective_address = ea_q;
	assign offset_value = ofs_q;
	assign operand_is_word = word_q;
	assign memory_access = mem_q;
	assign operand_reg = opr_q;
	assign rm_reg = rmr_q;
	assign segment_sel = seg_q;

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!reset_n);

	a_size_from_opcode:
	assert property ((st_q == ST_OPC && take) |=> (word_q == $past(fetch_byte[`OFD_W_BIT])))
	else $error("operand size not taken from opcode bit");
	a_reg_form_direct:
	assert property ((st_q == ST_MODRM && take && fetch_byte[`OFD_MOD_F] == `OFD_MOD_REG) |=> ##1 (result_valid && !memory_access))
	else $error("register form did not finish without memory access");
	a_no_offset_kind0:
	assert property ((st_q == ST_DONE && mode_q == `OFD_MOD_NONE && rm_q != `OFD_RM_DIRECT) |=> (offset_value == `OFD_RST16))
	else $error("kind 00 offset not zero");
	a_sign_extend_low:
	assert property ((st_q == ST_DONE && mode_q == `OFD_MOD_S8) |=> (offset_value == {{8{$past(lo_q[7])}}, $past(lo_q)}))
	else $error("short offset not sign-extended");
	a_two_byte_offset:
	assert property ((st_q == ST_OFLO && take && mode_q == `OFD_MOD_W16) |=> (st_q == ST_OFHI) ##[0:64] (st_q == ST_DONE))
	else $error("long offset did not fetch high byte");
	a_direct_address:
	assert property ((st_q == ST_DONE && ea_bus.direct) |=> (effective_address == {$past(hi_q), $past(lo_q)}))
	else $error("direct address wrong");
	a_base_src_sum:
	assert property ((st_q == ST_DONE && mode_q != `OFD_MOD_REG && rm_q == 3'h0)
		|=> (effective_address == 16'($past(base_q) + $past(src_q) + $past(ea_bus.ofs_val))))
	else $error("base plus source index sum wrong");
	a_frame_dst_sum:
	assert property ((st_q == ST_DONE && mode_q != `OFD_MOD_REG && rm_q == 3'h3)
		|=> (effective_address == 16'($past(frame_q) + $past(dst_q) + $past(ea_bus.ofs_val))))
	else $error("frame plus destination index sum wrong");
	a_index_only_sum:
	assert property ((st_q == ST_DONE && mode_q != `OFD_MOD_REG && rm_q == 3'h5)
		|=> (effective_address == 16'($past(dst_q) + $past(ea_bus.ofs_val))))
	else $error("index only sum wrong");
	a_base_only_sum:
	assert property ((st_q == ST_DONE && mode_q != `OFD_MOD_REG && rm_q == 3'h7)
		|=> (effective_address == 16'($past(base_q) + $past(ea_bus.ofs_val))))
	else $error("base only sum wrong");
	a_offset_order:
	assert property ((st_q == ST_MODRM && take && fetch_byte[`OFD_MOD_F] == `OFD_MOD_S8) |=> (st_q == ST_OFLO))
	else $error("offset not expected after operand byte");
	a_psw_reserved:
	assert property ((psw_q & ~`OFD_PSW_MASK) == `OFD_RST16)
	else $error("status word reserved bit set");
	a_byte_reg_map:
	assert property (result_valid |-> (rm_reg[3] == !operand_is_word) && (rm_reg[2:0] == $past(rm_q)))
	else $error("register code mapping wrong");
	a_segment_map:
	assert property (result_valid |-> (segment_sel == ofd_seg_t'($past(regf_q[1:0]))))
	else $error("segment code mapping wrong");

	c_direct_done: cover property ((st_q == ST_DONE && ea_bus.direct) ##1 result_valid);
	c_long_offset: cover property ((st_q == ST_OFHI && take) ##1 (st_q == ST_DONE));
	c_register_form: cover property (result_valid && !memory_access);
	c_wrap_sum: cover property (st_q == ST_DONE && ea_bus.mem_access && (ea_bus.ea < base_q));
endmodule // ofd_decoder

//--- bench/ofd_fetch_model.sv
`timescale 1ns/1ps
module ofd_fetch_model (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic fetch_ready,
	input wire logic slow,
	output logic fetch_valid,
	output logic [7:0] fetch_byte
);
	logic [7:0] q[$];
	logic stall_q;
	task automatic push(input logic [7:0] b);
		q.push_back(b);
	endtask
	// a byte stays put until taken; slow mode idles every other cycle
	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			fetch_valid <= 1'b0;
			fetch_byte <= 8'h00;
			stall_q <= 1'b0;
		end else begin
			stall_q <= slow & ~stall_q;
			if (!fetch_valid || fetch_ready) begin
				if (q.size() > 0 && !(slow && !stall_q)) begin
					fetch_valid <= 1'b1;
					fetch_byte <= q.pop_front();
				end else begin
					fetch_valid <= 1'b0;
					// idle line keeps changing so a stale byte cannot pass as fresh
					fetch_byte <= ~fetch_byte;
				end
			end
		end
	end
endmodule // ofd_fetch_model

//--- bench/ofd_decoder_tb.sv
`timescale 1ns/1ps
`include "ofd_cfg.svh"
module ofd_decoder_tb;
	import ofd_pkg::*;
	logic clk_sys, reset_n, psel, penable, pwrite, pready, pslverr, slow, err;
	logic [7:0] paddr, fetch_byte;
	logic [31:0] pwdata, prdata, rd;
	logic fetch_valid, fetch_ready, result_valid, operand_is_word, memory_access;
	logic [15:0] effective_address, offset_value, psw_mask;
	ofd_reg_t operand_reg, rm_reg;
	ofd_seg_t segment_sel;
	integer fail_count = 0, samples_checked = 0, seed = 61;
	int base, frame, src, dst, ea, ofs, md, rm, rg, w, lo, hi, n;
	int flag_pos[9] = '{0, 2, 4, 6, 7, 8, 9, 10, 11};
	ofd_decoder i_ofd_decoder (.clk_sys(clk_sys), .reset_n(reset_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.fetch_valid(fetch_valid), .fetch_byte(fetch_byte), .fetch_ready(fetch_ready),
		.result_valid(result_valid), .effective_address(effective_address), .offset_value(offset_value),
		.operand_is_word(operand_is_word), .memory_access(memory_access), .operand_reg(operand_reg),
		.rm_reg(rm_reg), .segment_sel(segment_sel));
	ofd_fetch_model i_ofd_fetch_model (.clk_sys(clk_sys), .reset_n(reset_n), .fetch_ready(fetch_ready),
		.slow(slow), .fetch_valid(fetch_valid), .fetch_byte(fetch_byte));
	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic give_verdict;
		if (fail_count == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic e_err);
		int k;
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clk_sys);
			k++;
		end while (pready !== 1'b1 && k < 50);
		if (k >= 50) begin
			fail_count++;
			give_verdict();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		chk(err, e_err);
	endtask
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		slow = 1'b0;
		reset_n = 1'b0;
		repeat (2) @(posedge clk_sys);
		reset_n <= 1'b1;
		psw_mask = 16'h0000;
		foreach (flag_pos[i]) psw_mask[flag_pos[i]] = 1'b1;
		apb(1'b0, `OFD_A_PSW, 32'h0000_0000, 1'b0);
		chk(rd, 32'h0000_0000);
		foreach (flag_pos[i]) begin
			apb(1'b1, `OFD_A_PSW, 32'h0000_0001 << flag_pos[i], 1'b0);
			apb(1'b0, `OFD_A_PSW, 32'h0000_0000, 1'b0);
			chk(rd, 32'h0000_0001 << flag_pos[i]);
		end
		apb(1'b1, `OFD_A_PSW, 32'hffff_ffff, 1'b0);
		apb(1'b0, `OFD_A_PSW, 32'h0000_0000, 1'b0);
		chk(rd, {16'h0000, psw_mask});
		apb(1'b0, 8'h40, 32'h0000_0000, 1'b1);
		chk(rd, 32'h0000_0000);
		base = $random(seed) & 65535;
		frame = $random(seed) & 65535;
		src = $random(seed) & 65535;
		dst = $random(seed) & 65535;
		apb(1'b1, `OFD_A_BASE, base, 1'b0);
		apb(1'b1, `OFD_A_FRAME, frame, 1'b0);
		apb(1'b1, `OFD_A_SRC, src, 1'b0);
		apb(1'b1, `OFD_A_DST, dst, 1'b0);
		apb(1'b1, `OFD_A_CTRL, 32'h0000_0001, 1'b0);
		// all 32 kind and rm pairs, random sizes, registers and offsets
		for (int i = 0; i < 40; i++) begin
			md = i % 4;
			rm = (i / 4) % 8;
			rg = $random(seed) & 7;
			w = $random(seed) & 1;
			lo = $random(seed) & 255;
			hi = $random(seed) & 255;
			// random pacing, so every kind also meets a stalling stream
			n = $random(seed);
			slow <= n[0];
			i_ofd_fetch_model.push({7'h44, w[0]});
			i_ofd_fetch_model.push({md[1:0], rg[2:0], rm[2:0]});
			if (md == 1 || md == 2 || (md == 0 && rm == 6)) i_ofd_fetch_model.push(lo[7:0]);
			if (md == 2 || (md == 0 && rm == 6)) i_ofd_fetch_model.push(hi[7:0]);
			ofs = (md == 1) ? ((lo ^ 128) - 128) & 65535 : (md == 2) ? hi * 256 + lo : 0;
			case (rm)
				0: ea = base + src;
				1: ea = base + dst;
				2: ea = frame + src;
				3: ea = frame + dst;
				4: ea = src;
				5: ea = dst;
				6: ea = frame;
				default: ea = base;
			endcase
			ea = (ea + ofs) & 65535;
			if (md == 0 && rm == 6) ea = hi * 256 + lo;
			if (md == 3) ea = 0;
			n = 0;
			do begin
				@(posedge clk_sys);
				n++;
			end while (result_valid !== 1'b1 && n < 100);
			if (n >= 100) begin
				fail_count++;
				give_verdict();
			end
			chk(effective_address, ea);
			if (!(md == 0 && rm == 6)) chk(offset_value, ofs);
			chk(operand_is_word, w);
			chk(memory_access, md != 3);
			chk(operand_reg, {~w[0], rg[2:0]});
			chk(segment_sel, rg[1:0]);
			if (md == 3) chk(rm_reg, {~w[0], rm[2:0]});
			apb(1'b0, `OFD_A_EA, 32'h0000_0000, 1'b0);
			chk(rd, ea);
		end
		apb(1'b0, `OFD_A_INFO, 32'h0000_0000, 1'b0);
		chk(rd, {20'h0_0000, rg[1:0], ~w[0], rm[2:0], ~w[0], rg[2:0], md != 3, w[0]});
		apb(1'b1, `OFD_A_EA, 32'h0000_1234, 1'b0);
		apb(1'b0, `OFD_A_EA, 32'h0000_0000, 1'b0);
		chk(rd, ea);
		give_verdict();
	end
endmodule // ofd_decoder_tb
